/* rtl/spc_pkg.sv */
// Shared constants and types for the scan-based pulse counter
package spc_pkg;
  localparam int          SPC_CNT_W      = 32;
  localparam int          SPC_WORD_W     = 16;
  localparam int          SPC_UPPER_LSB  = 16;
  localparam logic [31:0] SPC_COUNT_RST  = 32'h0000_0000;
  localparam logic [31:0] SPC_ZERO       = 32'h0000_0000;
  localparam logic [31:0] SPC_ONE        = 32'h0000_0001;
  localparam logic [1:0]  SPC_SYNC_RST   = 2'h0;
  localparam logic        SPC_DIR_UP_RST = 1'b1;

  typedef enum logic {
    SPC_MODE_SINGLE,
    SPC_MODE_TWO_PHASE
  } spc_mode_t;

  typedef enum logic {
    SPC_STAGE_FIRST,
    SPC_STAGE_SECOND
  } spc_stage_t;
endpackage

/* rtl/spc_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module spc_sync
  import spc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial begin
    if (WIDTH < 1) $error("spc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

/* rtl/spc_counter.sv */
// Scan-synchronous high-speed pulse counter with preset comparison
`timescale 1ns/1ps
`default_nettype none
module spc_counter
  import spc_pkg::*;
#(
  parameter int CNT_W = SPC_CNT_W
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET_N,
  input  wire logic                  PULSE_PHASE_A_INPUT,
  input  wire logic                  DIRECTION_OR_PHASE_B_INPUT,
  input  wire logic                  COUNTER_RELOAD_INPUT,
  input  wire logic                  SCAN_END,
  input  wire logic                  RUN_MODE,
  input  wire logic                  PROGRAM_LOAD,
  input  wire logic                  TWO_PHASE_MODE,
  input  wire logic                  COUNT_GATE,
  input  wire logic                  MATCH_OUTPUT_CLEAR,
  input  wire logic                  CLEAR_SELECT_SECOND,
  input  wire logic                  TWO_PRESETS,
  input  wire logic                  KEEP_FIRST,
  input  wire logic                  KEEP_SECOND,
  input  wire logic                  RELOAD_ENABLE,
  input  wire logic [SPC_WORD_W-1:0] PRESET_UPPER,
  input  wire logic [SPC_WORD_W-1:0] PRESET_LOWER,
  input  wire logic [SPC_WORD_W-1:0] PRESET2_UPPER,
  input  wire logic [SPC_WORD_W-1:0] PRESET2_LOWER,
  input  wire logic [SPC_WORD_W-1:0] RELOAD_VALUE_UPPER,
  input  wire logic [SPC_WORD_W-1:0] RELOAD_VALUE_LOWER,
  output logic      [SPC_WORD_W-1:0] CURRENT_COUNT_UPPER,
  output logic      [SPC_WORD_W-1:0] CURRENT_COUNT_LOWER,
  output logic      [SPC_WORD_W-1:0] ACTIVE_PRESET_UPPER,
  output logic      [SPC_WORD_W-1:0] ACTIVE_PRESET_LOWER,
  output logic                       FIRST_MATCH_OUTPUT,
  output logic                       SECOND_MATCH_OUTPUT,
  output logic                       RELOAD_DONE_PULSE,
  output logic                       MATCH_PULSE,
  output logic                       COUNT_DIRECTION_UP,
  output logic                       COUNTING
);
  initial begin
    if (CNT_W != 2 * SPC_WORD_W) $error("spc_counter: CNT_W must be two words");
    if (SPC_UPPER_LSB != SPC_WORD_W) $error("spc_counter: upper word must sit above lower word");
  end

  function automatic logic [CNT_W-1:0] join_words(input logic [SPC_WORD_W-1:0] hi,
                                                  input logic [SPC_WORD_W-1:0] lo);
    join_words = {hi, lo};
  endfunction

  // Rising edge of a level against its last value
  function automatic logic rose(input logic now_v,
                                input logic prev_v);
    rose = now_v && !prev_v;
  endfunction

  // Scan event bookkeeping, shared by both status pulses
  function automatic logic hold_event(input logic scan_v,
                                      input logic seen_v,
                                      input logic event_v);
    hold_event = scan_v ? 1'b0 : (seen_v || event_v);
  endfunction

  function automatic logic publish_event(input logic scan_v,
                                         input logic seen_v,
                                         input logic event_v,
                                         input logic pulse_v);
    publish_event = scan_v ? (seen_v || event_v) : pulse_v;
  endfunction

  // Pin inputs pass two flip-flops
  logic [2:0] pins_sync;
  spc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .d       ({COUNTER_RELOAD_INPUT, DIRECTION_OR_PHASE_B_INPUT, PULSE_PHASE_A_INPUT}),
    .q       (pins_sync)
  );

  wire        pin_a      = pins_sync[0];
  wire        pin_b      = pins_sync[1];
  wire        pin_reload = pins_sync[2];
  // Mode is a level; change it only with the gate off
  spc_mode_t  mode;
  assign mode = TWO_PHASE_MODE ? SPC_MODE_TWO_PHASE : SPC_MODE_SINGLE;

  logic             a_ff;
  logic             reload_ff;
  logic             gate_ff;
  logic             run_ff;
  logic             armed_ff;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] visible_ff;
  logic [CNT_W-1:0] preset_ff;
  spc_stage_t       stage_ff;
  logic             q1_ff;
  logic             q2_ff;
  logic             reload_seen_ff;
  logic             match_seen_ff;
  logic             reload_pulse_ff;
  logic             match_pulse_ff;
  logic             dir_ff;
  logic             holding_ff;

  // Armed on gate rise while running, or run entry with gate on
  wire gate_rise   = rose(COUNT_GATE, gate_ff);
  wire run_rise    = rose(RUN_MODE, run_ff);
  // A finished program load is no run entry; only a new run or a gate rise re-arms
  wire nxt_armed   = PROGRAM_LOAD ? 1'b0 :
                     !COUNT_GATE || !RUN_MODE ? 1'b0 :
                     (gate_rise || run_rise) ? 1'b1 : armed_ff;
  wire count_en    = armed_ff && COUNT_GATE && RUN_MODE && !PROGRAM_LOAD && !holding_ff;

  // Edge detection on synchronised phases
  // B edges alone never step; A carries every count
  wire a_rise      = rose(pin_a, a_ff);
  wire a_fall      = rose(a_ff, pin_a);
  wire step_single = a_rise;
  wire up_single   = pin_b;
  // 2-edge: count on A edges; direction by B level relative to A
  wire step_two    = a_rise || a_fall;
  wire up_two      = a_rise ? !pin_b : pin_b;
  wire step        = (mode == SPC_MODE_TWO_PHASE) ? step_two : step_single;
  wire step_up     = (mode == SPC_MODE_TWO_PHASE) ? up_two : up_single;

  wire reload_req  = RELOAD_ENABLE && rose(pin_reload, reload_ff);
  wire [CNT_W-1:0] reload_val = join_words(RELOAD_VALUE_UPPER, RELOAD_VALUE_LOWER);
  wire [CNT_W-1:0] preset1    = join_words(PRESET_UPPER, PRESET_LOWER);
  wire [CNT_W-1:0] preset2    = join_words(PRESET2_UPPER, PRESET2_LOWER);
  wire [CNT_W-1:0] stepped    = step_up ? count_ff + SPC_ONE : count_ff - SPC_ONE;
  wire [CNT_W-1:0] after_step = (count_en && step) ? stepped : count_ff;

  // Comparison on the freshly stepped value
  wire hit        = count_en && step && (stepped == preset_ff);
  wire hit_first  = hit && (stage_ff == SPC_STAGE_FIRST);
  wire hit_second = hit && (stage_ff == SPC_STAGE_SECOND);
  wire keep_now   = hit_first ? KEEP_FIRST : KEEP_SECOND;
  wire clr_now    = hit_second && !KEEP_SECOND && TWO_PRESETS;

  // Reload beats the second-preset clear, which beats a step
  logic [CNT_W-1:0] nxt_count;
  always_comb begin
    if (reload_req) begin
      nxt_count = reload_val;
    end else if (clr_now) begin
      nxt_count = SPC_ZERO;
    end else begin
      nxt_count = after_step;
    end
  end

  // Keep freezes counting until the next reload
  wire nxt_holding = reload_req ? 1'b0 : (hit && keep_now) ? 1'b1 : holding_ff;

  spc_stage_t nxt_stage;
  always_comb begin
    nxt_stage = stage_ff;
    if (reload_req) begin
      nxt_stage = SPC_STAGE_FIRST;
    end else begin
      unique case (stage_ff)
        SPC_STAGE_FIRST: begin
          if (hit_first && TWO_PRESETS) begin
            nxt_stage = SPC_STAGE_SECOND;
          end
        end
        SPC_STAGE_SECOND: begin
          if (hit_second) begin
            nxt_stage = SPC_STAGE_FIRST;
          end
        end
      endcase
    end
  end
  wire [CNT_W-1:0] nxt_preset = (nxt_stage == SPC_STAGE_SECOND) ? preset2 : preset1;

  // Set wins over clear on the latched outputs
  wire q1_set   = hit_first;
  wire q2_set   = hit_second && TWO_PRESETS;
  wire q1_clr   = MATCH_OUTPUT_CLEAR && !CLEAR_SELECT_SECOND;
  wire q2_clr   = MATCH_OUTPUT_CLEAR && CLEAR_SELECT_SECOND;
  wire nxt_q1   = q1_set || (q1_ff && !q1_clr);
  wire nxt_q2   = q2_set || (q2_ff && !q2_clr);

  // Events captured mid-scan, published for exactly one scan
  wire nxt_reload_seen = hold_event(SCAN_END, reload_seen_ff, reload_req);
  wire nxt_match_seen  = hold_event(SCAN_END, match_seen_ff, hit);
  wire nxt_reload_pls  = publish_event(SCAN_END, reload_seen_ff, reload_req, reload_pulse_ff);
  wire nxt_match_pls   = publish_event(SCAN_END, match_seen_ff, hit, match_pulse_ff);
  wire nxt_visible     = SCAN_END;

  // Two-phase flag follows the direction at the last match
  wire nxt_dir = (mode == SPC_MODE_SINGLE) ? up_single :
                 hit ? step_up : dir_ff;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      a_ff      <= 1'b0;
      reload_ff <= 1'b0;
    end else begin
      a_ff      <= pin_a;
      reload_ff <= pin_reload;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      gate_ff   <= 1'b0;
      run_ff    <= 1'b0;
      armed_ff  <= 1'b0;
    end else begin
      gate_ff   <= COUNT_GATE;
      run_ff    <= RUN_MODE;
      armed_ff  <= nxt_armed;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      count_ff   <= SPC_COUNT_RST;
      holding_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      holding_ff <= nxt_holding;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      preset_ff  <= SPC_COUNT_RST;
      stage_ff   <= SPC_STAGE_FIRST;
    end else begin
      preset_ff  <= nxt_preset;
      stage_ff   <= nxt_stage;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      visible_ff <= SPC_COUNT_RST;
    end else if (nxt_visible) begin
      visible_ff <= nxt_count;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      q1_ff           <= 1'b0;
      q2_ff           <= 1'b0;
    end else begin
      q1_ff           <= nxt_q1;
      q2_ff           <= nxt_q2;
    end
  end

  // One-scan status pulses
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      reload_seen_ff  <= 1'b0;
      match_seen_ff   <= 1'b0;
      reload_pulse_ff <= 1'b0;
      match_pulse_ff  <= 1'b0;
    end else begin
      reload_seen_ff  <= nxt_reload_seen;
      match_seen_ff   <= nxt_match_seen;
      reload_pulse_ff <= nxt_reload_pls;
      match_pulse_ff  <= nxt_match_pls;
    end
  end

  // Direction flag, upward after reset
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      dir_ff          <= SPC_DIR_UP_RST;
    end else begin
      dir_ff          <= nxt_dir;
    end
  end

  assign CURRENT_COUNT_UPPER = visible_ff[CNT_W-1:SPC_UPPER_LSB];
  assign CURRENT_COUNT_LOWER = visible_ff[SPC_WORD_W-1:0];
  assign ACTIVE_PRESET_UPPER = preset_ff[CNT_W-1:SPC_UPPER_LSB];
  assign ACTIVE_PRESET_LOWER = preset_ff[SPC_WORD_W-1:0];
  assign FIRST_MATCH_OUTPUT  = q1_ff;
  assign SECOND_MATCH_OUTPUT = q2_ff;
  assign RELOAD_DONE_PULSE   = reload_pulse_ff;
  assign MATCH_PULSE         = match_pulse_ff;
  assign COUNT_DIRECTION_UP  = dir_ff;
  // Held after a keep match reads as not counting
  assign COUNTING            = armed_ff && !holding_ff;
endmodule
`default_nettype wire

/* dv/spc_counter_properties.sv */
// Port-level checks for the scan-based pulse counter
`timescale 1ns/1ps
`default_nettype none
module spc_counter_properties
  import spc_pkg::*;
(
  input wire logic                  CLK_SYS,
  input wire logic                  RESET_N,
  input wire logic                  SCAN_END,
  input wire logic                  RUN_MODE,
  input wire logic                  PROGRAM_LOAD,
  input wire logic                  COUNT_GATE,
  input wire logic                  MATCH_OUTPUT_CLEAR,
  input wire logic                  CLEAR_SELECT_SECOND,
  input wire logic [SPC_WORD_W-1:0] CURRENT_COUNT_UPPER,
  input wire logic [SPC_WORD_W-1:0] CURRENT_COUNT_LOWER,
  input wire logic                  FIRST_MATCH_OUTPUT,
  input wire logic                  SECOND_MATCH_OUTPUT,
  input wire logic                  RELOAD_DONE_PULSE,
  input wire logic                  MATCH_PULSE,
  input wire logic                  COUNTING
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  sequence s_gate_off; !COUNT_GATE [*3]; endsequence
  sequence s_stopped; !RUN_MODE [*3]; endsequence
  sequence s_loading; PROGRAM_LOAD [*3]; endsequence
  sequence s_clear_idle; MATCH_OUTPUT_CLEAR && !CLEAR_SELECT_SECOND && !COUNTING; endsequence
  chk_reload_at_scan: assert property ($changed(RELOAD_DONE_PULSE) |-> $past(SCAN_END))
    else $error("reload pulse moved off a scan boundary");
  chk_reload_one_scan: assert property (RELOAD_DONE_PULSE && SCAN_END |=> !RELOAD_DONE_PULSE)
    else $error("reload pulse longer than one scan");
  chk_match_at_scan: assert property ($changed(MATCH_PULSE) |-> $past(SCAN_END))
    else $error("match pulse moved off a scan boundary");
  chk_count_at_scan: assert property ($changed({CURRENT_COUNT_UPPER, CURRENT_COUNT_LOWER}) |-> $past(SCAN_END))
    else $error("visible count changed inside a scan");
  chk_match_has_output: assert property ($rose(MATCH_PULSE) |-> FIRST_MATCH_OUTPUT || SECOND_MATCH_OUTPUT)
    else $error("match pulse without a match output");
  chk_first_latched: assert property (FIRST_MATCH_OUTPUT && !(MATCH_OUTPUT_CLEAR && !CLEAR_SELECT_SECOND) |=> FIRST_MATCH_OUTPUT)
    else $error("first output dropped without its clear");
  chk_second_latched: assert property (SECOND_MATCH_OUTPUT && !(MATCH_OUTPUT_CLEAR && CLEAR_SELECT_SECOND) |=> SECOND_MATCH_OUTPUT)
    else $error("second output dropped without its clear");
  chk_first_cleared: assert property (s_clear_idle |=> !FIRST_MATCH_OUTPUT)
    else $error("first output survived its clear");
  chk_gate_stops: assert property (s_gate_off |-> !COUNTING)
    else $error("counting with the gate low");
  chk_stop_halts: assert property (s_stopped |-> !COUNTING)
    else $error("counting while stopped");
  chk_load_halts: assert property (s_loading |-> !COUNTING)
    else $error("counting during program load");
endmodule
bind spc_counter spc_counter_properties u_spc_counter_properties (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .SCAN_END(SCAN_END), .RUN_MODE(RUN_MODE), .PROGRAM_LOAD(PROGRAM_LOAD), .COUNT_GATE(COUNT_GATE),
  .MATCH_OUTPUT_CLEAR(MATCH_OUTPUT_CLEAR), .CLEAR_SELECT_SECOND(CLEAR_SELECT_SECOND),
  .CURRENT_COUNT_UPPER(CURRENT_COUNT_UPPER), .CURRENT_COUNT_LOWER(CURRENT_COUNT_LOWER),
  .FIRST_MATCH_OUTPUT(FIRST_MATCH_OUTPUT), .SECOND_MATCH_OUTPUT(SECOND_MATCH_OUTPUT),
  .RELOAD_DONE_PULSE(RELOAD_DONE_PULSE), .MATCH_PULSE(MATCH_PULSE), .COUNTING(COUNTING));
`default_nettype wire

/* dv/spc_pulse_src.sv */
// Pulse source model: single-phase pulses or two-phase quadrature
`timescale 1ns/1ps
`default_nettype none
module spc_pulse_src (
  input  wire logic clk,
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // Levels held 4 cycles, beyond sync and edge detect
  task automatic step(input logic a, input logic b);
    @(negedge clk);
    pin_a = a;
    pin_b = b;
    repeat (3) @(negedge clk);
  endtask
  task automatic emit(input int n, input logic up, input logic quad);
    repeat (n) begin
      if (!quad) begin
        step(1'b0, up);
        step(1'b1, up);
      end else begin
        step(up, !up);
        step(1'b1, 1'b1);
        step(!up, up);
        step(1'b0, 1'b0);
      end
    end
    step(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

/* dv/scan_based_pulse_counter_test.sv */
// Self-checking bench for the scan-based pulse counter
`timescale 1ns/1ps
`default_nettype none
module scan_based_pulse_counter_test
  import spc_pkg::*;
;
  logic clk, rst_n, rld, scan, run, pload, quad, gate, clr, csel, two, k1, k2, rlen, seen;
  logic q1, q2, rdp, mp, dir, cnting;
  logic [SPC_WORD_W-1:0] p1l, p2l, rvl, rvu, ccu, ccl, apl, apu;
  wire logic pa, pb;
  logic [33:0] notes[$];
  logic [33:0] note;
  int bad_count = 0;
  int comparisons = 0;
  spc_counter u_spc_counter (
    .CLK_SYS(clk), .RESET_N(rst_n), .PULSE_PHASE_A_INPUT(pa), .DIRECTION_OR_PHASE_B_INPUT(pb),
    .COUNTER_RELOAD_INPUT(rld), .SCAN_END(scan), .RUN_MODE(run), .PROGRAM_LOAD(pload),
    .TWO_PHASE_MODE(quad), .COUNT_GATE(gate), .MATCH_OUTPUT_CLEAR(clr), .CLEAR_SELECT_SECOND(csel),
    .TWO_PRESETS(two), .KEEP_FIRST(k1), .KEEP_SECOND(k2), .RELOAD_ENABLE(rlen),
    .PRESET_UPPER(rvu), .PRESET_LOWER(p1l), .PRESET2_UPPER(rvu), .PRESET2_LOWER(p2l),
    .RELOAD_VALUE_UPPER(rvu), .RELOAD_VALUE_LOWER(rvl), .CURRENT_COUNT_UPPER(ccu),
    .CURRENT_COUNT_LOWER(ccl), .ACTIVE_PRESET_UPPER(apu), .ACTIVE_PRESET_LOWER(apl),
    .FIRST_MATCH_OUTPUT(q1), .SECOND_MATCH_OUTPUT(q2), .RELOAD_DONE_PULSE(rdp), .MATCH_PULSE(mp),
    .COUNT_DIRECTION_UP(dir), .COUNTING(cnting));
  spc_pulse_src u_spc_pulse_src (.clk(clk), .pin_a(pa), .pin_b(pb));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Scan end every 16 cycles
  initial begin
    scan = 1'b0;
    forever begin
      repeat (15) @(negedge clk);
      scan = 1'b1;
      @(negedge clk);
      scan = 1'b0;
    end
  end
  always @(posedge clk) seen <= scan;
  always @(negedge clk) begin
    if (seen === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      check({q2, q1, ccu, ccl}, note);
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [33:0] got, input logic [33:0] want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, got, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic expect_count(input logic f1, input logic f2, input logic [31:0] c);
    int i;
    repeat (6) @(negedge clk);
    notes.push_back({f2, f1, c});
    for (i = 0; i < 60 && notes.size() > 0; i++) @(negedge clk);
    if (notes.size() > 0) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic wait_pulse(input logic sel_match);
    int i;
    for (i = 0; i < 100 && (sel_match ? mp : rdp) !== 1'b1; i++) @(negedge clk);
    if (i == 100) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic reload();
    rld = 1'b1;
    repeat (4) @(negedge clk);
    rld = 1'b0;
  endtask
  initial begin
    logic [15:0] lf;
    logic [31:0] r;
    {rst_n, rld, pload, quad, gate, clr, csel, two, k2} = '0;
    {run, k1, rlen} = 3'h7;
    lf = lfsr(16'hCBE5);
    rvl = {8'h00, lf[7:0]};
    rvu = {8'h00, lf[15:8]};
    p1l = rvl + 16'h0006;
    p2l = rvl + 16'h0008;
    r = {rvu, rvl};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    reload();
    wait_pulse(1'b0);
    check(rdp, 1'b1);
    repeat (17) @(negedge clk);
    check(rdp, 1'b0);
    expect_count(1'b0, 1'b0, r);
    u_spc_pulse_src.emit(2, 1'b1, 1'b0);
    expect_count(1'b0, 1'b0, r);
    $display("test reload and gate-off done");
    gate = 1'b1;
    u_spc_pulse_src.emit(3, 1'b1, 1'b0);
    expect_count(1'b0, 1'b0, r + 32'h3);
    u_spc_pulse_src.emit(1, 1'b0, 1'b0);
    expect_count(1'b0, 1'b0, r + 32'h2);
    u_spc_pulse_src.emit(4, 1'b1, 1'b0);
    wait_pulse(1'b1);
    u_spc_pulse_src.emit(2, 1'b1, 1'b0);
    expect_count(1'b1, 1'b0, r + 32'h6);
    {csel, clr} = 2'h3;
    expect_count(1'b1, 1'b0, r + 32'h6);
    csel = 1'b0;
    expect_count(1'b0, 1'b0, r + 32'h6);
    clr = 1'b0;
    $display("test single-phase and match done");
    reload();
    pload = 1'b1;
    repeat (3) @(negedge clk);
    pload = 1'b0;
    u_spc_pulse_src.emit(2, 1'b1, 1'b0);
    expect_count(1'b0, 1'b0, r);
    run = 1'b0;
    repeat (4) @(negedge clk);
    run = 1'b1;
    u_spc_pulse_src.emit(1, 1'b1, 1'b0);
    expect_count(1'b0, 1'b0, r + 32'h1);
    $display("test load and run control done");
    {quad, two, k1} = 3'h6;
    reload();
    u_spc_pulse_src.emit(3, 1'b1, 1'b1);
    expect_count(1'b1, 1'b0, r + 32'h6);
    check(apl, p2l);
    check(apu, rvu);
    u_spc_pulse_src.emit(1, 1'b0, 1'b1);
    expect_count(1'b1, 1'b0, r + 32'h4);
    check(dir, 1'b1);
    u_spc_pulse_src.emit(2, 1'b1, 1'b1);
    expect_count(1'b1, 1'b1, 32'h0000_0000);
    check(dir, 1'b1);
    check(apl, p1l);
    $display("test two-phase chain done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
